// [hw/pc_loader_regs.svh]
`ifndef PC_LOADER_REGS_SVH
`define PC_LOADER_REGS_SVH

// register byte offsets on the bus
`define LOW_BYTE_OFFSET     12'h000
`define HIGH_LATCH_OFFSET   12'h004
`define STATUS_OFFSET       12'h008
`define CONTROL_OFFSET      12'h00C

// field positions
`define STATUS_WRAP_BIT     16
`define STATUS_KIND_LSB     17
`define STATUS_KIND_MSB     19
`define CONTROL_HOLD_BIT    0

// widths and reset values
`define PC_WIDTH            15
`define LATCH_WIDTH         7
`define PC_RESET            15'h0000
`define LATCH_RESET         7'h00
`define PC_ONE              15'h0001

// timing: wait states inserted by the bus slave
`define APB_WAIT_STATES     1

`endif

// [hw/pc_loader_pkg.sv]
`default_nettype none

package pc_loader_pkg;

    // load case requested by the instruction decoder
    typedef enum logic [2:0] {
        op_none                           = 3'h0,
        op_write_low_byte                 = 3'h1,
        op_add_working_to_file            = 3'h2,
        op_call                           = 3'h3,
        op_call_via_working_register      = 3'h4,
        op_branch_by_working_register     = 3'h5,
        op_branch_by_immediate            = 3'h6,
        op_write_high_latch               = 3'h7
    } pc_op_t;

    // bus slave states, gray along idle -> wait -> done
    typedef enum logic [1:0] {
        apb_idle = 2'b00,
        apb_wait = 2'b01,
        apb_done = 2'b11
    } apb_state_t;

endpackage

`default_nettype wire

// [hw/pc_target_calc.sv]
`include "pc_loader_regs.svh"
`default_nettype none

module pc_target_calc (
    input  wire logic [2:0]  op_kind,
    input  wire logic [14:0] pc,
    input  wire logic [6:0]  latch,
    input  wire logic [10:0] operand,
    input  wire logic [7:0]  working,
    input  wire logic [7:0]  file_result,
    output logic             loads_pc,
    output logic      [14:0] target,
    output logic             low_carry
);

    // address of the next instruction, wraps in 15 bits
    function automatic logic [14:0] inc15(input logic [14:0] a);
        inc15 = a + `PC_ONE;
    endfunction

    logic [14:0] pc_plus_one;
    logic [8:0]  low_sum;
    logic [14:0] imm_ext;

    always_comb begin
        pc_plus_one = inc15(pc);
        low_sum     = {1'b0, pc_plus_one[7:0]} + {1'b0, working};
        imm_ext     = {{6{operand[8]}}, operand[8:0]};
        loads_pc    = 1'b1;
        target      = inc15(pc);
        low_carry   = 1'b0;
        case (pc_loader_pkg::pc_op_t'(op_kind))
            pc_loader_pkg::op_write_low_byte: begin
                target = {latch, file_result};
            end
            pc_loader_pkg::op_add_working_to_file: begin
                // carry out of the low byte goes out on low_carry only, upper from latch
                target    = {latch, low_sum[7:0]};
                low_carry = low_sum[8];
            end
            pc_loader_pkg::op_call: begin
                target = {latch[6:3], operand};
            end
            pc_loader_pkg::op_call_via_working_register: begin
                target = {latch, working};
            end
            pc_loader_pkg::op_branch_by_working_register: begin
                // full width sum, may leave the 256-byte block
                target = pc_plus_one + {7'h00, working};
            end
            pc_loader_pkg::op_branch_by_immediate: begin
                target = pc_plus_one + imm_ext;
            end
            default: begin
                loads_pc = 1'b0;
                target   = inc15(pc);
            end
        endcase
    end

endmodule // pc_target_calc

`default_nettype wire

// [hw/apb_wait_ctrl.sv]
`default_nettype none

module apb_wait_ctrl (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic psel,
    input  wire logic penable,
    input  wire logic pwrite,
    output logic      pready,
    output logic      read_load,
    output logic      write_fire
);

    pc_loader_pkg::apb_state_t state_ff;
    pc_loader_pkg::apb_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pc_loader_pkg::apb_idle: begin
                if (psel && !penable) begin
                    nxt_state = pc_loader_pkg::apb_wait;
                end
            end
            pc_loader_pkg::apb_wait: begin
                if (psel && penable) begin
                    nxt_state = pc_loader_pkg::apb_done;
                end else if (!psel) begin
                    nxt_state = pc_loader_pkg::apb_idle;
                end
            end
            pc_loader_pkg::apb_done: begin
                nxt_state = pc_loader_pkg::apb_idle;
            end
            default: begin
                nxt_state = pc_loader_pkg::apb_idle;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_ff <= pc_loader_pkg::apb_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // one wait state gives read data time to reach a flip-flop
    assign pready     = (state_ff == pc_loader_pkg::apb_done);
    assign read_load  = (state_ff == pc_loader_pkg::apb_wait) && psel &&
                        penable && !pwrite;
    assign write_fire = pready && psel && penable && pwrite;

endmodule // apb_wait_ctrl

`default_nettype wire

// [hw/program_counter_loader.sv]
// What this block does
// - a 15-bit program counter addresses program memory.
// - the low byte is a read/write register, upper bits come from the latch.
// - every reset clears the whole counter to zero.
// - writing the low byte copies the latch into the upper bits at once.
// - adding to the low byte gives an 8-bit result with latch upper bits.
// - an absolute call takes 11 operand bits and latch bits 6 to 3.
// - a call via the working register takes it as low byte, latch as upper.
// - a working-register branch loads next address plus unsigned offset.
// - an immediate branch loads next address plus signed operand bits 8 to 0.
// - both branch forms change all 15 bits, crossing blocks freely.
`include "pc_loader_regs.svh"
`default_nettype none

module program_counter_loader (
    input  wire logic        clock,
    input  wire logic        nrst,
    // register bus
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // instruction decoder
    input  wire logic        op_valid,
    input  wire logic [2:0]  op_kind,
    input  wire logic [10:0] op_operand,
    input  wire logic [7:0]  working_reg,
    input  wire logic [7:0]  file_result,
    // fetch path
    input  wire logic        fetch_advance,
    output logic      [14:0] pc,
    output logic      [7:0]  low_byte_value,
    output logic      [6:0]  high_latch_value,
    output logic             wrap_flag
);

    ////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic is_offset(input logic [11:0] a,
                                       input logic [11:0] off);
        is_offset = (a == off);
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = is_offset(a, `LOW_BYTE_OFFSET)   ||
                    is_offset(a, `HIGH_LATCH_OFFSET) ||
                    is_offset(a, `STATUS_OFFSET)     ||
                    is_offset(a, `CONTROL_OFFSET);
    endfunction

    // status layout in one place so fields move with the header
    function automatic logic [31:0] status_word(input logic [2:0]  kind,
                                                input logic        wrap,
                                                input logic [14:0] count);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[14:0] = count;
        w[`STATUS_WRAP_BIT] = wrap;
        w[`STATUS_KIND_MSB:`STATUS_KIND_LSB] = kind;
        status_word = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // architectural state, read by several sections below

    logic [14:0] pc_ff;
    logic [6:0]  latch_ff;
    logic        hold_ff;

    ////////////////////////////////////////////////////////////////////////
    // bus handshake

    logic read_load;
    logic write_fire;

    apb_wait_ctrl u_apb_wait_ctrl (
        .clock      (clock),
        .nrst       (nrst),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .pready     (pready),
        .read_load  (read_load),
        .write_fire (write_fire)
    );

    logic wr_low;
    logic wr_latch;
    logic wr_status;
    logic wr_control;

    assign wr_low     = write_fire && pstrb[0] &&
                        is_offset(paddr, `LOW_BYTE_OFFSET);
    assign wr_latch   = write_fire && pstrb[0] &&
                        is_offset(paddr, `HIGH_LATCH_OFFSET);
    assign wr_status  = write_fire && pstrb[2] &&
                        is_offset(paddr, `STATUS_OFFSET);
    assign wr_control = write_fire && pstrb[0] &&
                        is_offset(paddr, `CONTROL_OFFSET);

    ////////////////////////////////////////////////////////////////////////
    // target selection

    logic        calc_loads_pc;
    logic [14:0] calc_target;
    logic        calc_carry;
    logic [2:0]  eff_kind;

    // no valid op means plain advance
    assign eff_kind = op_valid ? op_kind : 3'h0;

    pc_target_calc u_pc_target_calc (
        .op_kind     (eff_kind),
        .pc          (pc_ff),
        .latch       (latch_ff),
        .operand     (op_operand),
        .working     (working_reg),
        .file_result (file_result),
        .loads_pc    (calc_loads_pc),
        .target      (calc_target),
        .low_carry   (calc_carry)
    );

    ////////////////////////////////////////////////////////////////////////
    // program counter and latch

    logic [14:0] nxt_pc;
    logic [6:0]  nxt_latch;
    logic        core_latch_write;
    logic        core_pc_load;
    logic        bus_low_load;
    logic        bus_latch_load;
    logic        advance_ok;

    assign core_latch_write = op_valid &&
        (pc_loader_pkg::pc_op_t'(op_kind) ==
         pc_loader_pkg::op_write_high_latch);
    assign core_pc_load     = op_valid && calc_loads_pc;
    // a core op in the same cycle wins and the bus write is lost
    assign bus_low_load     = wr_low && !op_valid;
    assign bus_latch_load   = wr_latch && !op_valid;
    assign advance_ok       = fetch_advance && !hold_ff;

    always_comb begin
        nxt_pc = pc_ff;
        if (core_pc_load) begin
            nxt_pc = calc_target;
        end else if (bus_low_load) begin
            nxt_pc = {latch_ff, pwdata[7:0]};
        end else if (advance_ok) begin
            // calc gives pc plus one when no op loads the counter
            nxt_pc = calc_target;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pc_ff <= `PC_RESET;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    always_comb begin
        nxt_latch = latch_ff;
        if (core_latch_write) begin
            nxt_latch = file_result[6:0];
        end else if (bus_latch_load) begin
            nxt_latch = pwdata[6:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            latch_ff <= `LATCH_RESET;
        end else begin
            latch_ff <= nxt_latch;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status and control

    logic       wrap_ff;
    logic       nxt_wrap;
    logic [2:0] last_kind_ff;
    logic [2:0] nxt_last_kind;
    logic       nxt_hold;
    logic       wrap_event;
    logic       wrap_clear;

    // a table that ran off its 256-byte block is worth telling software
    assign wrap_event = op_valid && calc_carry;
    assign wrap_clear = wr_status && pwdata[`STATUS_WRAP_BIT];

    // set wins so an event in the clearing cycle is not lost
    always_comb begin
        nxt_wrap = wrap_ff;
        if (wrap_event) begin
            nxt_wrap = 1'b1;
        end else if (wrap_clear) begin
            nxt_wrap = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            wrap_ff <= 1'b0;
        end else begin
            wrap_ff <= nxt_wrap;
        end
    end

    always_comb begin
        nxt_last_kind = last_kind_ff;
        if (core_pc_load) begin
            nxt_last_kind = op_kind;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            last_kind_ff <= 3'h0;
        end else begin
            last_kind_ff <= nxt_last_kind;
        end
    end

    always_comb begin
        nxt_hold = hold_ff;
        if (wr_control) begin
            nxt_hold = pwdata[`CONTROL_HOLD_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            hold_ff <= 1'b0;
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data

    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic        pslverr_ff;
    logic        nxt_pslverr;
    logic [31:0] read_word;

    // upper bits of the counter are only visible through status
    always_comb begin
        read_word = 32'h0000_0000;
        if (is_offset(paddr, `LOW_BYTE_OFFSET)) begin
            read_word = {24'h00_0000, pc_ff[7:0]};
        end else if (is_offset(paddr, `HIGH_LATCH_OFFSET)) begin
            read_word = {25'h000_0000, latch_ff};
        end else if (is_offset(paddr, `STATUS_OFFSET)) begin
            read_word = status_word(last_kind_ff, wrap_ff, pc_ff);
        end else if (is_offset(paddr, `CONTROL_OFFSET)) begin
            read_word = {31'h0000_0000, hold_ff};
        end
    end

    always_comb begin
        nxt_prdata = prdata_ff;
        if (read_load) begin
            nxt_prdata = read_word;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            prdata_ff <= 32'h0000_0000;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    // error bit is worked out in the wait cycle, shown only with pready
    always_comb begin
        nxt_pslverr = 1'b0;
        if (read_load) begin
            nxt_pslverr = !is_mapped(paddr);
        end else if (psel && penable && pwrite && !pready) begin
            nxt_pslverr = !is_mapped(paddr);
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= nxt_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata           = prdata_ff;
    assign pslverr          = pslverr_ff && pready;
    assign pc               = pc_ff;
    assign low_byte_value   = pc_ff[7:0];
    assign high_latch_value = latch_ff;
    assign wrap_flag        = wrap_ff;

endmodule // program_counter_loader

`default_nettype wire

// [test/program_counter_loader_checker.sv]
`default_nettype none

module program_counter_loader_checker (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        op_valid,
    input wire logic [2:0]  op_kind,
    input wire logic [10:0] op_operand,
    input wire logic [7:0]  working_reg,
    input wire logic [7:0]  file_result,
    input wire logic        fetch_advance,
    input wire logic [14:0] pc,
    input wire logic [7:0]  low_byte_value,
    input wire logic [6:0]  high_latch_value
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [14:0] imm_ext;
    logic [3:0]  latch_top;
    logic        go;

    assign imm_ext   = {{6{op_operand[8]}}, op_operand[8:0]};
    assign latch_top = high_latch_value[6:3];
    assign go        = op_valid;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////
    a_reset_clear: assert property (disable iff (1'b0) !nrst |=>
        pc == 15'h0000 && high_latch_value == 7'h00) else $error("no clear");
    a_low_mirror: assert property (low_byte_value == pc[7:0])
        else $error("low byte differs from pc");
    a_low_write: assert property (go && op_kind == 3'h1 |=>
        pc == {$past(high_latch_value), $past(file_result)})
        else $error("low byte load wrong");
    a_add_block: assert property (go && op_kind == 3'h2 |=>
        pc == {$past(high_latch_value), 8'($past(low_byte_value)
        + 8'h01 + $past(working_reg))}) else $error("add target wrong");
    a_call_abs: assert property (go && op_kind == 3'h3 |=>
        pc == {$past(latch_top), $past(op_operand)})
        else $error("call target wrong");
    a_call_work: assert property (go && op_kind == 3'h4 |=>
        pc == {$past(high_latch_value), $past(working_reg)})
        else $error("working call wrong");
    a_branch_work: assert property (go && op_kind == 3'h5 |=>
        pc == 15'($past(pc) + 15'h0001 + 15'($past(working_reg))))
        else $error("working branch wrong");
    a_branch_imm: assert property (go && op_kind == 3'h6 |=>
        pc == 15'($past(pc) + 15'h0001 + $past(imm_ext)))
        else $error("immediate branch wrong");
    a_pc_stands: assert property (!go && !fetch_advance && !psel |=>
        $stable(pc)) else $error("pc moved while idle");
    a_ready_wait: assert property (psel && !penable |=>
        !pready ##1 pready) else $error("bus answer timing wrong");
    a_bad_addr: assert property (pready && paddr[11:4] != 8'h00 |->
        pslverr) else $error("unmapped access not refused");
    a_latch_load: assert property (go && op_kind == 3'h7 |=>
        high_latch_value == 7'($past(file_result)))
        else $error("latch load wrong");
endmodule // program_counter_loader_checker

bind program_counter_loader program_counter_loader_checker
    u_program_counter_loader_checker (.clock(clock), .nrst(nrst),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_kind(op_kind),
    .op_operand(op_operand), .working_reg(working_reg),
    .file_result(file_result), .fetch_advance(fetch_advance), .pc(pc),
    .low_byte_value(low_byte_value), .high_latch_value(high_latch_value));

`default_nettype wire

// [test/decoder_model.sv]
`default_nettype none

module decoder_model (
    input  wire logic        clock,
    output logic             op_valid,
    output logic      [2:0]  op_kind,
    output logic      [10:0] op_operand,
    output logic      [7:0]  working_reg,
    output logic      [7:0]  file_result,
    output logic             fetch_advance
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        {op_valid, op_kind, op_operand, working_reg} = '0;
        {file_result, fetch_advance} = '0;
    end

    // released lines flip so stale operands never look valid
    task automatic issue(input logic [2:0] k, input logic [10:0] o,
                         input logic [7:0] w, input logic [7:0] f);
        @(posedge clock);
        op_valid <= 1'b1;
        op_kind <= k;
        op_operand <= o;
        working_reg <= w;
        file_result <= f;
        @(posedge clock);
        op_valid <= 1'b0;
        op_operand <= ~o;
        working_reg <= ~w;
        file_result <= ~f;
    endtask

    task automatic advance(input int n);
        @(posedge clock);
        fetch_advance <= 1'b1;
        repeat (n) @(posedge clock);
        fetch_advance <= 1'b0;
    endtask
endmodule // decoder_model

`default_nettype wire

// [test/program_counter_loader_tb.sv]
`include "pc_loader_regs.svh"
`default_nettype none

module program_counter_loader_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock, nrst, psel, penable, pwrite, pready, pslverr, wrap_flag;
    logic op_valid, fetch_advance;
    logic [2:0]  op_kind;
    logic [10:0] op_operand;
    logic [7:0]  working_reg, file_result, low_byte_value;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [14:0] pc, epc;
    logic [6:0]  high_latch_value, lat;
    logic        er;
    int          bad_count, checks, cyc;

    program_counter_loader u_program_counter_loader (.clock(clock),
        .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
        .op_kind(op_kind), .op_operand(op_operand),
        .working_reg(working_reg), .file_result(file_result),
        .fetch_advance(fetch_advance), .pc(pc),
        .low_byte_value(low_byte_value),
        .high_latch_value(high_latch_value), .wrap_flag(wrap_flag));

    decoder_model u_decoder_model (.clock(clock), .op_valid(op_valid),
        .op_kind(op_kind), .op_operand(op_operand),
        .working_reg(working_reg), .file_result(file_result),
        .fetch_advance(fetch_advance));

    always #2.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, x);
        checks++;
        if (s !== x) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask

    // request stands until pready is sampled high at a rising edge
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic op(input logic [2:0] k, input logic [10:0] o,
                      input logic [7:0] w, input logic [7:0] f);
        logic [14:0] p1;
        p1 = epc + 15'h0001;
        case (k)
            3'h1: epc = {lat, f};
            3'h2: epc = {lat, 8'(p1[7:0] + w)};
            3'h3: epc = {lat[6:3], o};
            3'h4: epc = {lat, w};
            3'h5: epc = p1 + 15'(w);
            3'h6: epc = p1 + {{6{o[8]}}, o[8:0]};
            default: lat = f[6:0];
        endcase
        u_decoder_model.issue(k, o, w, f);
        @(negedge clock);
        chk("pc", 32'(pc), 32'(epc));
        chk("latch", 32'(high_latch_value), 32'(lat));
    endtask

    initial begin
        {clock, nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        chk("reset pc", 32'(pc), 32'h0);
        bus(1'b1, `HIGH_LATCH_OFFSET, 32'h0000_0055);
        bus(1'b1, `LOW_BYTE_OFFSET, 32'h0000_00AB);
        @(negedge clock);
        chk("bus load", 32'(pc), 32'h0000_55AB);
        bus(1'b0, `LOW_BYTE_OFFSET, 32'h0);
        chk("low read", rd, 32'h0000_00AB);
        bus(1'b0, `HIGH_LATCH_OFFSET, 32'h0);
        chk("latch read", rd, 32'h0000_0055);
        epc = 15'h55AB;
        lat = 7'h55;
        op(3'h7, 11'h0, 8'h0, 8'h2A);
        op(3'h1, 11'h0, 8'h0, 8'hF0);
        op(3'h2, 11'h0, 8'h20, 8'h0);
        chk("wrap", 32'(wrap_flag), 32'h1);
        bus(1'b0, `STATUS_OFFSET, 32'h0);
        chk("status", rd, 32'({4'h5, 1'b0, epc}));
        pstrb <= 4'hB;
        bus(1'b1, `STATUS_OFFSET, 32'h0001_0000);
        pstrb <= 4'hF;
        @(negedge clock);
        chk("lane off", 32'(wrap_flag), 32'h1);
        bus(1'b1, `STATUS_OFFSET, 32'h0001_0000);
        @(negedge clock);
        chk("wrap clr", 32'(wrap_flag), 32'h0);
        op(3'h3, 11'h7FF, 8'h0, 8'h0);
        op(3'h4, 11'h0, 8'h3C, 8'h0);
        op(3'h5, 11'h0, 8'hFF, 8'h0);
        op(3'h6, 11'h100, 8'h0, 8'h0);
        op(3'h6, 11'h0FF, 8'h0, 8'h0);
        op(3'h7, 11'h0, 8'h0, 8'h7F);
        op(3'h1, 11'h0, 8'h0, 8'hFF);
        u_decoder_model.advance(1);
        @(negedge clock);
        chk("top wrap", 32'(pc), 32'h0);
        epc = 15'h0000;
        op(3'h6, 11'h1FD, 8'h0, 8'h0);
        bus(1'b1, `CONTROL_OFFSET, 32'h1);
        u_decoder_model.advance(3);
        @(negedge clock);
        chk("held", 32'(pc), 32'(epc));
        bus(1'b1, `CONTROL_OFFSET, 32'h0);
        u_decoder_model.advance(3);
        @(negedge clock);
        chk("advance", 32'(pc), 32'(15'(epc + 15'h0003)));
        bus(1'b0, 12'h010, 32'h0);
        chk("unmapped", {rd[30:0], er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        @(posedge clock);
        nrst <= 1'b0;
        @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        chk("rerun", 32'({high_latch_value, pc}), 32'h0);
        finish_test();
    end
endmodule // program_counter_loader_tb

`default_nettype wire
